// [rtl/led_dim_pkg.sv]
// Purpose: Shared constants of the LED buck switch and dimming control.
// Assumes: One 20 MHz clock, synchronous active-low reset.
// Notes: Levels are 8-bit fractions of target current, 8'hFF is full current.
//
// Operation
// - Switch off once sense voltage rises above the upper threshold.
// - Switch on once sense voltage falls below the lower threshold.
// - Analog dimming sets sense reference proportional to level, 100% down to 12.5%.
// - Below 12.5% hold reference at 12.5% and modulate output on and off.
// - Hybrid modulation runs at typically 3.4 kHz.
// - Modulation frequency fixed; measured duty maps through hybrid curve.
// - Input duty is high time divided by period.
// - Stage off below off threshold, back on above higher on threshold.
// - Abrupt dimming changes, including dim-to-off, ramp current softly.
// - Duty sets ramp target, input frequency sets ramp speed.
// - Step count depends on distance; ramp ends at target in time.
// - Small dimming changes apply directly without ramping.
// - Open dimming input means full level with full soft-start.
// - Low power mode after shutdown low longer than low qualification time.
// - Leave low power after shutdown high longer than high qualification time.
// - Over-temperature stops switching until release indication, with hysteresis.
// - Over-temperature waits for clearing and never causes low power mode.
// - Gate-drive undervoltage lock pauses switching until it clears.
package led_dim_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int CLK_NS = 50;
    // Hybrid modulation frequency; the period count rounds down.
    localparam int HYB_FREQ_HZ = 3400;
    localparam int HYB_PERIOD_CYC = CLK_HZ / HYB_FREQ_HZ;
    localparam int HYB_W = 13;
    // No rising input edge for this long means a static dimming pin.
    localparam int DIM_TIMEOUT_US = 5000;
    localparam int DIM_TIMEOUT_CYC = DIM_TIMEOUT_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 17;
    // Shutdown qualification times.
    localparam int SD_LO_US = 100;
    localparam int SD_HI_US = 100;
    localparam int SD_LO_CYC = SD_LO_US * (CLK_HZ / 1000000);
    localparam int SD_HI_CYC = SD_HI_US * (CLK_HZ / 1000000);
    localparam int LVL_W = 8;
    localparam logic [7:0] LEVEL_FULL = 8'hFF;
    localparam logic [7:0] LEVEL_ZERO = 8'h00;
    localparam logic [7:0] HYB_FLOOR = 8'h20;
    localparam logic [7:0] OFF_TH_DEF = 8'h01;
    localparam logic [7:0] ON_TH_DEF = 8'h03;
    localparam logic [7:0] SMALL_STEP_DEF = 8'h04;
    localparam int RAMP_SHIFT_DEF = 2;
    localparam int SYNC_N = 7;
    typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} div_state_t;
endpackage

// [rtl/shutdown_qualifier.sv]
// Purpose: Qualify the synchronised active-low shutdown level into low power mode.
// Assumes: level_in is already synchronised to clk_in.
// Notes: A glitch shorter than the qualification time restarts the count.
module shutdown_qualifier #(
    parameter int LO_CYC = led_dim_pkg::SD_LO_CYC,
    parameter int HI_CYC = led_dim_pkg::SD_HI_CYC
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic level_in,
    output logic low_power_out
);
    import led_dim_pkg::*;

    logic lp_q, lp_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] limit;
    logic disagree;

    // ****************************************
    // Qualification counter
    // ****************************************
    // The count runs only while the pin disagrees with the present mode.
    always_comb begin
        limit = lp_q ? CNT_W'(HI_CYC) : CNT_W'(LO_CYC);
        disagree = lp_q ? level_in : !level_in;
        lp_d = lp_q;
        cnt_d = '0;
        if (disagree) begin
            if (cnt_q == limit) begin
                lp_d = !lp_q;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            lp_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            lp_q <= lp_d;
            cnt_q <= cnt_d;
        end
    end

    assign low_power_out = lp_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_mode_after_qual: assert property ($changed(lp_q) |-> $past(cnt_q) == $past(limit) && $past(disagree))
        else $error("Low power mode changed without full qualification.");
    a_enter_needs_low: assert property ($rose(lp_q) |-> $past(!level_in, 1) && $past(!level_in, 2))
        else $error("Low power entered while shutdown was high.");
    a_exit_needs_high: assert property ($fell(lp_q) |-> $past(level_in, 1) && $past(level_in, 2))
        else $error("Low power left while shutdown was low.");
endmodule

// [rtl/led_buck_dimming_control.sv]
// Purpose: Hysteretic switch gating, PWM duty measurement, soft ramp and hybrid dimming.
// Assumes: All pin inputs are asynchronous; the analog comparators use sense_ref_out.
// Notes: Comparator results arrive two cycles late through the synchronisers.
module led_buck_dimming_control #(
    parameter int HYB_PERIOD = led_dim_pkg::HYB_PERIOD_CYC,
    parameter int DIM_TIMEOUT = led_dim_pkg::DIM_TIMEOUT_CYC,
    parameter int SD_LO = led_dim_pkg::SD_LO_CYC,
    parameter int SD_HI = led_dim_pkg::SD_HI_CYC,
    parameter logic [7:0] OFF_TH = led_dim_pkg::OFF_TH_DEF,
    parameter logic [7:0] ON_TH = led_dim_pkg::ON_TH_DEF,
    parameter logic [7:0] SMALL_STEP = led_dim_pkg::SMALL_STEP_DEF,
    parameter int RAMP_SHIFT = led_dim_pkg::RAMP_SHIFT_DEF
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic dim_pwm_in,
    input wire logic shutdown_n_input_in,
    input wire logic upper_sense_threshold_in,
    input wire logic lower_sense_threshold_in,
    input wire logic overtemp_trip_level_in,
    input wire logic overtemp_release_level_in,
    input wire logic gate_drive_undervolt_lock_in,
    output logic switch_on_out,
    output logic [led_dim_pkg::LVL_W-1:0] sense_ref_out,
    output logic hybrid_active_out,
    output logic low_power_out,
    output logic stage_on_out,
    output logic [led_dim_pkg::LVL_W-1:0] duty_out,
    output logic [led_dim_pkg::LVL_W-1:0] ramp_level_out
);
    import led_dim_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [SYNC_N-1:0] meta_q, sync_q;
    logic dim_s, sd_s, cs_hi_s, cs_lo_s, ot_trip_s, ot_rel_s, gate_drive_undervolt_lock_s;

    // Every pin passes two flip-flops; only sync_q is read by logic.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {dim_pwm_in, shutdown_n_input_in, upper_sense_threshold_in,
                       lower_sense_threshold_in, overtemp_trip_level_in,
                       overtemp_release_level_in, gate_drive_undervolt_lock_in};
            sync_q <= meta_q;
        end
    end

    assign {dim_s, sd_s, cs_hi_s, cs_lo_s, ot_trip_s, ot_rel_s, gate_drive_undervolt_lock_s} = sync_q;

    // ****************************************
    // Low power mode
    // ****************************************
    logic lp;

    shutdown_qualifier #(
        .LO_CYC(SD_LO),
        .HI_CYC(SD_HI)
    ) u_sd_qual (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .level_in(sd_s),
        .low_power_out(lp)
    );

    // ****************************************
    // Duty measurement
    // ****************************************
    logic dim_prev_q, dim_prev_d;
    logic seen_q, seen_d;
    logic [CNT_W-1:0] per_cnt_q, per_cnt_d, hi_cnt_q, hi_cnt_d, per_l_q, per_l_d;
    logic [CNT_W:0] rem_q, rem_d, shifted;
    logic [7:0] quo_q, quo_d, duty_q, duty_d;
    logic [2:0] bit_q, bit_d;
    div_state_t div_q, div_d;
    logic tick_q, tick_d;
    logic rise, timeout;

    // Period and high time are counted in clocks from one rising edge to the next.
    // A restoring divider then forms high * 256 / period over eight cycles.
    always_comb begin
        rise = dim_s && !dim_prev_q;
        timeout = (per_cnt_q == CNT_W'(DIM_TIMEOUT));
        dim_prev_d = dim_s;
        seen_d = seen_q;
        per_cnt_d = per_cnt_q + 1'b1;
        hi_cnt_d = hi_cnt_q + {{(CNT_W-1){1'b0}}, dim_s};
        per_l_d = per_l_q;
        rem_d = rem_q;
        quo_d = quo_q;
        bit_d = bit_q;
        div_d = div_q;
        duty_d = duty_q;
        tick_d = 1'b0;
        shifted = {rem_q[CNT_W-1:0], 1'b0};
        if (rise) begin
            per_cnt_d = {{(CNT_W-1){1'b0}}, 1'b1};
            hi_cnt_d = {{(CNT_W-1){1'b0}}, 1'b1};
            seen_d = 1'b1;
            if (seen_q && div_q == DIV_IDLE) begin
                per_l_d = per_cnt_q;
                rem_d = {1'b0, hi_cnt_q};
                quo_d = 8'h00;
                bit_d = 3'h0;
                div_d = DIV_RUN;
            end
        end else if (timeout) begin
            per_cnt_d = '0;
            hi_cnt_d = '0;
            seen_d = 1'b0;
            duty_d = dim_s ? LEVEL_FULL : LEVEL_ZERO;
            tick_d = 1'b1;
        end
        case (div_q)
            DIV_IDLE: begin
            end
            DIV_RUN: begin
                if (shifted >= {1'b0, per_l_q}) begin
                    rem_d = shifted - {1'b0, per_l_q};
                    quo_d = {quo_q[6:0], 1'b1};
                end else begin
                    rem_d = shifted;
                    quo_d = {quo_q[6:0], 1'b0};
                end
                bit_d = bit_q + 1'b1;
                if (bit_q == 3'h7) begin
                    duty_d = quo_d;
                    tick_d = 1'b1;
                    div_d = DIV_IDLE;
                end
            end
            default: div_d = DIV_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            dim_prev_q <= 1'b0;
            seen_q <= 1'b0;
            per_cnt_q <= '0;
            hi_cnt_q <= '0;
            per_l_q <= '0;
            rem_q <= '0;
            quo_q <= 8'h00;
            bit_q <= 3'h0;
            div_q <= DIV_IDLE;
            duty_q <= LEVEL_ZERO;
            tick_q <= 1'b0;
        end else begin
            dim_prev_q <= dim_prev_d;
            seen_q <= seen_d;
            per_cnt_q <= per_cnt_d;
            hi_cnt_q <= hi_cnt_d;
            per_l_q <= per_l_d;
            rem_q <= rem_d;
            quo_q <= quo_d;
            bit_q <= bit_d;
            div_q <= div_d;
            duty_q <= duty_d;
            tick_q <= tick_d;
        end
    end

    // ****************************************
    // Dim-to-off and soft ramp
    // ****************************************
    logic stage_on_q, stage_on_d;
    logic [7:0] ramp_q, ramp_d, target, diff, step;

    // Outside low power the ramp moves only on a measured period or a pin timeout, so a slow input ramps slowly.
    // Large distances take big steps first, which bounds the number of periods.
    always_comb begin
        stage_on_d = stage_on_q;
        ramp_d = ramp_q;
        if (tick_q) begin
            if (stage_on_q) begin
                stage_on_d = !(duty_q < OFF_TH);
            end else begin
                stage_on_d = duty_q > ON_TH;
            end
        end
        target = stage_on_d ? duty_q : LEVEL_ZERO;
        diff = (target > ramp_q) ? target - ramp_q : ramp_q - target;
        step = (diff >> RAMP_SHIFT) + 8'h01;
        if (lp) begin
            ramp_d = LEVEL_ZERO;
        end else if (tick_q) begin
            if (diff <= SMALL_STEP) begin
                ramp_d = target;
            end else if (target > ramp_q) begin
                ramp_d = ramp_q + step;
            end else begin
                ramp_d = ramp_q - step;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            stage_on_q <= 1'b1;
            ramp_q <= LEVEL_ZERO;
        end else begin
            stage_on_q <= stage_on_d;
            ramp_q <= ramp_d;
        end
    end

    // ****************************************
    // Hybrid modulation and reference
    // ****************************************
    logic [HYB_W-1:0] hyb_cnt_q, hyb_cnt_d;
    logic [HYB_W+7:0] prod;
    logic [7:0] mod_cmp, ref_q, ref_d;
    logic hybrid, mod_on, hyb_q;

    // The modulation counter runs free, unrelated to the input frequency.
    // Below the floor the level scales by eight into a modulation duty.
    always_comb begin
        hyb_cnt_d = (hyb_cnt_q == HYB_W'(HYB_PERIOD - 1)) ? '0 : hyb_cnt_q + 1'b1;
        hybrid = ramp_q < HYB_FLOOR;
        mod_cmp = {ramp_q[4:0], 3'b000};
        prod = {{HYB_W{1'b0}}, mod_cmp} * {8'h00, HYB_W'(HYB_PERIOD)};
        mod_on = hyb_cnt_q < prod[HYB_W+7:8];
        ref_d = hybrid ? HYB_FLOOR : ramp_q;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            hyb_cnt_q <= '0;
            ref_q <= HYB_FLOOR;
            hyb_q <= 1'b1;
        end else begin
            hyb_cnt_q <= hyb_cnt_d;
            ref_q <= ref_d;
            hyb_q <= hybrid;
        end
    end

    // ****************************************
    // Protection and switch gating
    // ****************************************
    logic ot_q, ot_d, sw_q, sw_d, run;

    // Over-temperature has its own latch; it only blocks switching and
    // leaves the low power mode to the shutdown pin alone.
    always_comb begin
        ot_d = ot_q;
        if (ot_trip_s) begin
            ot_d = 1'b1;
        end else if (ot_rel_s) begin
            ot_d = 1'b0;
        end
        run = !lp && !ot_q && !gate_drive_undervolt_lock_s && ramp_q != LEVEL_ZERO && (!hybrid || mod_on);
        sw_d = sw_q;
        if (!run) begin
            sw_d = 1'b0;
        end else if (cs_hi_s) begin
            sw_d = 1'b0;
        end else if (cs_lo_s) begin
            sw_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ot_q <= 1'b0;
            sw_q <= 1'b0;
        end else begin
            ot_q <= ot_d;
            sw_q <= sw_d;
        end
    end

    assign switch_on_out = sw_q;
    assign sense_ref_out = ref_q;
    assign hybrid_active_out = hyb_q;
    assign low_power_out = lp;
    assign stage_on_out = stage_on_q;
    assign duty_out = duty_q;
    assign ramp_level_out = ramp_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_sw_off_high: assert property (cs_hi_s |=> !switch_on_out)
        else $error("Switch stayed on above upper threshold.");
    a_sw_on_low: assert property (run && cs_lo_s && !cs_hi_s |=> switch_on_out)
        else $error("Switch not on below lower threshold.");
    a_ref_analog: assert property (!hybrid |=> sense_ref_out == $past(ramp_q))
        else $error("Reference does not follow analog level.");
    a_ref_floor_hyb: assert property (hybrid |=> sense_ref_out == HYB_FLOOR && hybrid_active_out)
        else $error("Reference not held at floor in hybrid.");
    a_mod_wrap: assert property (hyb_cnt_q == HYB_W'(HYB_PERIOD - 1) |=> hyb_cnt_q == '0)
        else $error("Modulation period wrong.");
    a_stage_off_th: assert property (tick_q && stage_on_q && duty_q < OFF_TH |=> !stage_on_q)
        else $error("Stage not off below off threshold.");
    a_stage_on_th: assert property (!stage_on_q && $changed(stage_on_q) == 0 ##1 stage_on_q
                                    |-> $past(duty_q) > ON_TH)
        else $error("Stage on without passing on threshold.");
    a_ramp_on_tick: assert property ($changed(ramp_q) |-> $past(tick_q) || $past(lp))
        else $error("Ramp moved without a period tick.");
    a_ot_block: assert property (ot_q |=> !switch_on_out)
        else $error("Switching during over-temperature.");
    a_gate_drive_undervolt_lock_block: assert property (gate_drive_undervolt_lock_s |=> !switch_on_out)
        else $error("Switching during gate-drive undervoltage.");
    a_lp_no_switch: assert property (lp |=> !switch_on_out && ramp_q == LEVEL_ZERO)
        else $error("Switching in low power mode.");
endmodule

// [test/dim_host_model.sv]
// Purpose: Host side model that drives the dimming pin and the shutdown pin.
// Assumes: Pins change only at the falling clock edge.
// Notes: Period and high time are given in clock cycles.
module dim_host_model (
    input wire logic clk_in,
    input wire logic pwm_run_in,
    input wire logic [15:0] high_cyc_in,
    input wire logic [15:0] period_cyc_in,
    input wire logic sleep_req_in,
    output logic dim_pwm_out,
    output logic shutdown_n_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] phase_q;

    // Start with both pins high, as the pulled-up pins would be.
    initial begin
        phase_q = 16'h0000;
        dim_pwm_out = 1'b1;
        shutdown_n_out = 1'b1;
    end

    // dimming pin high
    // In sleep the dimming pin is held high; low power mode follows the shutdown pin alone.
    always @(negedge clk_in) begin
        shutdown_n_out <= !sleep_req_in;
        if (!pwm_run_in || sleep_req_in) begin
            phase_q <= 16'h0000;
            dim_pwm_out <= 1'b1;
        end else begin
            phase_q <= (phase_q + 16'h0001 >= period_cyc_in) ? 16'h0000 : phase_q + 16'h0001;
            dim_pwm_out <= (phase_q < high_cyc_in);
        end
    end
endmodule

// [test/tb_top.sv]
// Purpose: Self-checking bench of the switch gating, dimming, ramp and protection logic.
// Assumes: Short parameters for hybrid period, pin timeout and shutdown qualification.
// Notes: Inputs change at the falling edge; outputs are sampled there too.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_in, rst_b_in, dim_pwm, sd_n, upper, lower, trip, release_lvl, lock;
    logic pwm_run, sleep_req;
    logic [15:0] high_cyc, period_cyc;
    logic switch_on_out, hybrid_active_out, low_power_out, stage_on_out;
    logic [7:0] sense_ref_out, duty_out, ramp_level_out;
    int num_errors, checks_done;

    led_buck_dimming_control #(.HYB_PERIOD(64), .DIM_TIMEOUT(2000), .SD_LO(20), .SD_HI(20))
    led_buck_dimming_control_i (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .dim_pwm_in(dim_pwm), .shutdown_n_input_in(sd_n),
        .upper_sense_threshold_in(upper), .lower_sense_threshold_in(lower),
        .overtemp_trip_level_in(trip), .overtemp_release_level_in(release_lvl),
        .gate_drive_undervolt_lock_in(lock), .switch_on_out(switch_on_out),
        .sense_ref_out(sense_ref_out), .hybrid_active_out(hybrid_active_out),
        .low_power_out(low_power_out), .stage_on_out(stage_on_out), .duty_out(duty_out),
        .ramp_level_out(ramp_level_out));

    dim_host_model dim_host_model_i (.clk_in(clk_in), .pwm_run_in(pwm_run), .high_cyc_in(high_cyc),
        .period_cyc_in(period_cyc), .sleep_req_in(sleep_req), .dim_pwm_out(dim_pwm), .shutdown_n_out(sd_n));

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic set_pwm(input logic [15:0] h, input logic [15:0] p);
        @(negedge clk_in);
        high_cyc = h;
        period_cyc = p;
        pwm_run = 1'b1;
    endtask

    // Bounded wait so a stuck ramp reports a mismatch instead of hanging.
    task automatic wait_ramp(input logic [7:0] exp, input int n);
        int i;
        i = 0;
        while (ramp_level_out !== exp && i < n) begin
            @(negedge clk_in);
            i++;
        end
        chk8(ramp_level_out, exp);
    endtask

    task automatic wait_move(input logic [7:0] from, input int n);
        int i;
        i = 0;
        while (ramp_level_out === from && i < n) begin
            @(negedge clk_in);
            i++;
        end
    endtask

    task automatic settle;
        repeat (4) @(negedge clk_in);
    endtask

    // Counts switch-on cycles over ten hybrid periods of 64 cycles.
    task automatic count_on(output int n);
        n = 0;
        repeat (640) begin
            @(negedge clk_in);
            if (switch_on_out === 1'b1) n++;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic soft_start;
        set_pwm(16'h003F, 16'h0040);
        wait_move(8'h00, 400);
        chk8(ramp_level_out, 8'h40);
        chk8(duty_out, 8'hFC);
        wait_ramp(8'hFC, 1500);
        @(negedge clk_in);
        chk8(sense_ref_out, 8'hFC);
        chk1(hybrid_active_out, 1'b0);
    endtask

    task automatic small_change;
        int i;
        set_pwm(16'h003E, 16'h0040);
        i = 0;
        while (duty_out !== 8'hF8 && i < 300) begin
            @(negedge clk_in);
            i++;
        end
        repeat (2) @(negedge clk_in);
        chk8(ramp_level_out, 8'hF8);
    endtask

    task automatic switch_gate;
        lower = 1'b1;
        settle();
        chk1(switch_on_out, 1'b1);
        upper = 1'b1;
        settle();
        chk1(switch_on_out, 1'b0);
        lower = 1'b0;
        settle();
        upper = 1'b0;
        lower = 1'b1;
        settle();
        chk1(switch_on_out, 1'b1);
    endtask

    task automatic protections;
        trip = 1'b1;
        settle();
        chk1(switch_on_out, 1'b0);
        trip = 1'b0;
        repeat (60) @(negedge clk_in);
        chk1(switch_on_out, 1'b0);
        chk1(low_power_out, 1'b0);
        release_lvl = 1'b1;
        settle();
        chk1(switch_on_out, 1'b1);
        release_lvl = 1'b0;
        lock = 1'b1;
        settle();
        chk1(switch_on_out, 1'b0);
        lock = 1'b0;
        settle();
        chk1(switch_on_out, 1'b1);
    endtask

    task automatic hybrid;
        int n;
        set_pwm(16'h0004, 16'h0040);
        wait_ramp(8'h10, 3000);
        @(negedge clk_in);
        chk8(sense_ref_out, 8'h20);
        chk1(hybrid_active_out, 1'b1);
        count_on(n);
        chk_cnt(n, 320);
        set_pwm(16'h0008, 16'h0080);
        repeat (400) @(negedge clk_in);
        count_on(n);
        chk_cnt(n, 320);
    endtask

    // A held-low pin first gives a clean zero duty through the static-level path,
    // since a period change in mid-period would measure one odd transitional duty.
    task automatic dim_off;
        set_pwm(16'h0000, 16'h0200);
        wait_move(8'h10, 2500);
        chk8(duty_out, 8'h00);
        chk8(ramp_level_out, 8'h0B);
        chk1(stage_on_out, 1'b0);
        set_pwm(16'h0001, 16'h0200);
        wait_ramp(8'h00, 4000);
        chk1(stage_on_out, 1'b0);
        settle();
        chk1(switch_on_out, 1'b0);
        set_pwm(16'h0003, 16'h0100);
        repeat (1100) @(negedge clk_in);
        chk1(stage_on_out, 1'b0);
        set_pwm(16'h0004, 16'h0100);
        wait_ramp(8'h04, 1200);
        chk1(stage_on_out, 1'b1);
    endtask

    task automatic shutdown;
        pwm_run = 1'b0;
        sleep_req = 1'b1;
        repeat (10) @(negedge clk_in);
        sleep_req = 1'b0;
        repeat (40) @(negedge clk_in);
        chk1(low_power_out, 1'b0);
        sleep_req = 1'b1;
        repeat (40) @(negedge clk_in);
        chk1(low_power_out, 1'b1);
        chk8(ramp_level_out, 8'h00);
        chk1(switch_on_out, 1'b0);
        sleep_req = 1'b0;
        repeat (10) @(negedge clk_in);
        sleep_req = 1'b1;
        repeat (40) @(negedge clk_in);
        chk1(low_power_out, 1'b1);
        sleep_req = 1'b0;
        repeat (40) @(negedge clk_in);
        chk1(low_power_out, 1'b0);
        wait_move(8'h00, 2300);
        chk8(ramp_level_out, 8'h40);
        chk8(duty_out, 8'hFF);
    endtask

    // ****************************************
    // Clock, sequence, watchdog and verdict
    // ****************************************
    task automatic end_of_test;
        $display("mismatches %0d, comparisons %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Free-running 50 ns clock.
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Main sequence; reset spans 8 cycles before any stimulus.
    initial begin
        num_errors = 0;
        checks_done = 0;
        rst_b_in = 1'b0;
        {upper, lower, trip, release_lvl, lock, pwm_run, sleep_req} = 7'h00;
        high_cyc = 16'h0000;
        period_cyc = 16'h0040;
        repeat (8) @(negedge clk_in);
        rst_b_in = 1'b1;
        soft_start();
        small_change();
        switch_gate();
        protections();
        hybrid();
        dim_off();
        shutdown();
        end_of_test();
    end

    // The run needs about 12000 cycles; the limit leaves ample margin.
    initial begin
        #3000000;
        num_errors++;
        end_of_test();
    end
endmodule
